// ---- verilog/monitor_cfg_pkg.sv ----
// Shared constants and types for the monitor control bit bank
package monitor_cfg_pkg;

    // Register slots: global strobes, then unit 3 and unit 4 words
    localparam int NUM_REGS   = 5;
    localparam int REG_GLOBAL = 0;
    localparam int REG_U3_CM  = 1;
    localparam int REG_U3_TM  = 2;
    localparam int REG_U4_CM  = 3;
    localparam int REG_U4_TM  = 4;

    // System bus byte addresses, slot 4 leftmost
    localparam logic [NUM_REGS-1:0][31:0] SYS_ADDR = {
        32'h400202EC, 32'h400202E8, 32'h400202BC,
        32'h400202B8, 32'h40020220};
    // Analog engine byte addresses, slot 4 leftmost
    localparam logic [NUM_REGS-1:0][7:0] ACE_ADDR = {
        8'hBB, 8'hBA, 8'hAF, 8'hAE, 8'h88};

    // Field positions
    localparam int CM_BYPASS_BIT  = 0;
    localparam int CM_ISOLATE_BIT = 1;
    localparam int CM_ENABLE_BIT  = 2;
    localparam int CM_STROBE_BIT  = 3;
    localparam int COMP_EN_BIT    = 4;
    localparam int TM_BYPASS_BIT  = 0;
    localparam int TM_ISOLATE_BIT = 1;
    localparam int TM_STROBE_BIT  = 2;
    localparam int GSTB_U3_BIT    = 3;
    localparam int GSTB_U4_BIT    = 4;

    // Reset value and writable masks
    localparam logic [7:0] REG_RESET    = 8'h00;
    localparam logic [7:0] CM_MASK      = 8'h1F;
    localparam logic [7:0] TM_MASK      = 8'h07;
    localparam logic [7:0] GSTB_MASK    = 8'h18;
    localparam logic [7:0] GSTB_MASK_U3 = 8'h08;

    // Switch pattern {S1,S2,S3,S4} per phase, phase 4 leftmost
    localparam logic [4:0][3:0] TM_SWITCH_TABLE = {
        4'h2, 4'h3, 4'h1, 4'h5, 4'hD};

    // Timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int TM_PHASE_NS   = 1000;
    localparam int CM_SEQ_NS     = 1000;
    localparam int TM_PHASE_CYCLES =
        (TM_PHASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int CM_SEQ_CYCLES =
        (CM_SEQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TM_PHASES = 5;
    localparam int CM_PHASES = 3;

    // Controls presented to one conditioning unit's analog parts
    typedef struct packed {
        logic       curmonBypassSelect;
        logic       curmonIsolationClose;
        logic       curmonEnable;
        logic       curmonStrobe;
        logic       curmonTrack;
        logic       comparatorEnable;
        logic       tempmonBypassSelect;
        logic       tempmonIsolationClose;
        logic [3:0] tempmonSwitches;
        logic [2:0] tempmonPhase;
    } unit_out_type;

endpackage

// ---- verilog/monitor_sequencer.sv ----
// Phase stepper shared by current and temperature monitor control
`timescale 1ns/1ns
module monitor_sequencer #(
    parameter int NUM_PHASES  = 5,
    parameter int STEP_CYCLES = 100
) (
    input  wire logic                          sys_clk,
    input  wire logic                          resetn,
    input  wire logic                          strobe,
    output logic [$clog2(NUM_PHASES)-1:0]      phase,
    output logic                               lastPhase
);
    localparam int PW = $clog2(NUM_PHASES);
    localparam int CW = $clog2(STEP_CYCLES + 1);
    localparam logic [PW-1:0] LAST = PW'(NUM_PHASES - 1);
    localparam logic [CW-1:0] STEP_END = CW'(STEP_CYCLES - 1);

    // Refuse shapes the stepper cannot serve
    generate
        if (NUM_PHASES < 2 || STEP_CYCLES < 1)
        begin : g_bad
            $error("monitor_sequencer: bad phase count or step");
        end
    endgenerate

    logic [PW-1:0] phase_r;
    logic [PW-1:0] phase_nxt;
    logic [CW-1:0] count_r;
    logic [CW-1:0] count_nxt;
    logic          atLast;
    logic          stepDone;

    // Step timing; strobe low aborts to idle at once
    assign atLast    = phase_r == LAST;
    assign stepDone  = count_r == STEP_END;
    assign count_nxt = (!strobe || atLast || stepDone) ? '0
                                                       : count_r + 1'b1;
    assign phase_nxt = !strobe ? '0
                     : (stepDone && !atLast) ? phase_r + 1'b1
                     : phase_r;
    assign phase     = phase_r;
    assign lastPhase = atLast;

    // Phase and step counter registers
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            phase_r <= '0;
            count_r <= '0;
        end
        else
        begin
            phase_r <= phase_nxt;
            count_r <= count_nxt;
        end
    end

    sequence s_step_due;
        strobe && stepDone && !atLast;
    endsequence

    sequence s_next_phase;
        ##1 phase_r == $past(phase_r) + 1'b1;
    endsequence

    a_idle_on_drop: assert property (@(posedge sys_clk)
        disable iff (!resetn) !strobe |=> phase_r == '0)
        else $error("phase not idle after strobe drop");

    a_step_advance: assert property (@(posedge sys_clk)
        disable iff (!resetn) s_step_due |-> s_next_phase)
        else $error("phase did not advance at step end");

    a_hold_last: assert property (@(posedge sys_clk)
        disable iff (!resetn) atLast && strobe |=> atLast)
        else $error("last phase not held");

    a_no_skip: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        strobe && $past(strobe) && phase_r != $past(phase_r)
        |-> phase_r == $past(phase_r) + 1'b1)
        else $error("phase skipped");

endmodule

// ---- verilog/monitor_config_control_bits.sv ----
// Monitor configuration control bits for conditioning units 3 and 4
`timescale 1ns/1ns
module monitor_config_control_bits #(
    parameter bit HAS_UNIT4 = 1'b1,
    parameter int RESULT_W  = 12
) (
    input  wire logic                          sys_clk,
    input  wire logic                          resetn,
    input  wire logic [31:0]                   sysAddr,
    input  wire logic                          sysWrite,
    input  wire logic                          sysRead,
    input  wire logic [31:0]                   sysWdata,
    output logic [31:0]                        sysRdata,
    input  wire logic [7:0]                    aceAddr,
    input  wire logic                          aceWrite,
    input  wire logic                          aceRead,
    input  wire logic [7:0]                    aceWdata,
    output logic [7:0]                         aceRdata,
    input  wire logic [RESULT_W-1:0]           tmResult,
    input  wire logic                          tmResultValid,
    input  wire logic [RESULT_W-1:0]           tmFactoryOffset,
    output logic [RESULT_W-1:0]                tmCompResult,
    output logic                               tmCompValid,
    output monitor_cfg_pkg::unit_out_type      unit3Out,
    output monitor_cfg_pkg::unit_out_type      unit4Out
);
    localparam int N = monitor_cfg_pkg::NUM_REGS;

    generate
        if (RESULT_W < 2 || RESULT_W > 16)
        begin : g_bad
            $error("monitor_config_control_bits: bad RESULT_W");
        end
    endgenerate

    logic [7:0]          regs_r   [N];
    logic [7:0]          regs_nxt [N];
    logic [7:0]          wrMask   [N];
    logic [N-1:0]        sysHit;
    logic [N-1:0]        aceHit;
    logic [7:0]          sysSel;
    logic [7:0]          aceSel;
    logic [31:0]         sysRdata_r;
    logic [7:0]          aceRdata_r;
    logic [RESULT_W-1:0] comp_r;
    logic                compValid_r;
    logic                cm3Strobe;
    logic                cm4Strobe;
    logic                tm3Strobe;
    logic                tm4Strobe;
    logic [1:0]          cm3Phase;
    logic [1:0]          cm4Phase;
    logic [2:0]          tm3Phase;
    logic [2:0]          tm4Phase;
    logic                cm3Track;
    logic                cm4Track;

    // Writable bits per slot; unit 4 bits vanish when absent
    assign wrMask[monitor_cfg_pkg::REG_GLOBAL] = HAS_UNIT4
        ? monitor_cfg_pkg::GSTB_MASK : monitor_cfg_pkg::GSTB_MASK_U3;
    assign wrMask[monitor_cfg_pkg::REG_U3_CM] = monitor_cfg_pkg::CM_MASK;
    assign wrMask[monitor_cfg_pkg::REG_U3_TM] = monitor_cfg_pkg::TM_MASK;
    assign wrMask[monitor_cfg_pkg::REG_U4_CM] =
        HAS_UNIT4 ? monitor_cfg_pkg::CM_MASK : 8'h00;
    assign wrMask[monitor_cfg_pkg::REG_U4_TM] =
        HAS_UNIT4 ? monitor_cfg_pkg::TM_MASK : 8'h00;

    // Address decode and next value; system bus wins a collision
    genvar k;
    generate
        for (k = 0; k < N; k++)
        begin : g_reg
            assign sysHit[k] = sysAddr == monitor_cfg_pkg::SYS_ADDR[k];
            assign aceHit[k] = aceAddr == monitor_cfg_pkg::ACE_ADDR[k];
            assign regs_nxt[k] =
                (sysWrite && sysHit[k]) ? sysWdata[7:0] & wrMask[k]
              : (aceWrite && aceHit[k]) ? aceWdata & wrMask[k]
              : regs_r[k];

            always_ff @(posedge sys_clk)
            begin
                if (!resetn)
                    regs_r[k] <= monitor_cfg_pkg::REG_RESET;
                else
                    regs_r[k] <= regs_nxt[k];
            end
        end
    endgenerate

    // Read selection; unmapped addresses read zero
    always_comb
    begin
        sysSel = 8'h00;
        aceSel = 8'h00;
        for (int i = 0; i < N; i++)
        begin
            if (sysHit[i])
                sysSel = sysSel | regs_r[i];
            if (aceHit[i])
                aceSel = aceSel | regs_r[i];
        end
    end

    // Read data registers, upper bytes forced to zero
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            sysRdata_r <= 32'h00000000;
            aceRdata_r <= 8'h00;
        end
        else
        begin
            if (sysRead)
                sysRdata_r <= {24'h000000, sysSel};
            if (aceRead)
                aceRdata_r <= aceSel;
        end
    end

    assign sysRdata = sysRdata_r;
    assign aceRdata = aceRdata_r;

    // Effective strobes: current monitor local bit OR the unit's own bit in the global register; temperature strobes local bit only
    assign cm3Strobe =
        regs_r[monitor_cfg_pkg::REG_U3_CM][monitor_cfg_pkg::CM_STROBE_BIT]
      | regs_r[monitor_cfg_pkg::REG_GLOBAL][monitor_cfg_pkg::GSTB_U3_BIT];
    assign cm4Strobe =
        regs_r[monitor_cfg_pkg::REG_U4_CM][monitor_cfg_pkg::CM_STROBE_BIT]
      | regs_r[monitor_cfg_pkg::REG_GLOBAL][monitor_cfg_pkg::GSTB_U4_BIT];
    assign tm3Strobe =
        regs_r[monitor_cfg_pkg::REG_U3_TM][monitor_cfg_pkg::TM_STROBE_BIT];
    assign tm4Strobe =
        regs_r[monitor_cfg_pkg::REG_U4_TM][monitor_cfg_pkg::TM_STROBE_BIT];

    // Current monitor sequences: idle, start, track
    monitor_sequencer #(
        .NUM_PHASES  (monitor_cfg_pkg::CM_PHASES),
        .STEP_CYCLES (monitor_cfg_pkg::CM_SEQ_CYCLES)
    ) u_cm3 (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .strobe    (cm3Strobe),
        .phase     (cm3Phase),
        .lastPhase (cm3Track)
    );

    monitor_sequencer #(
        .NUM_PHASES  (monitor_cfg_pkg::CM_PHASES),
        .STEP_CYCLES (monitor_cfg_pkg::CM_SEQ_CYCLES)
    ) u_cm4 (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .strobe    (cm4Strobe),
        .phase     (cm4Phase),
        .lastPhase (cm4Track)
    );

    // Temperature monitor phase sequences, one per unit
    monitor_sequencer #(
        .NUM_PHASES  (monitor_cfg_pkg::TM_PHASES),
        .STEP_CYCLES (monitor_cfg_pkg::TM_PHASE_CYCLES)
    ) u_tm3 (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .strobe    (tm3Strobe),
        .phase     (tm3Phase),
        .lastPhase ()
    );

    monitor_sequencer #(
        .NUM_PHASES  (monitor_cfg_pkg::TM_PHASES),
        .STEP_CYCLES (monitor_cfg_pkg::TM_PHASE_CYCLES)
    ) u_tm4 (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .strobe    (tm4Strobe),
        .phase     (tm4Phase),
        .lastPhase ()
    );

    // Unit control outputs from the stored bits, effective strobes, sequencer phases and switch table
    assign unit3Out = '{
        curmonBypassSelect:    regs_r[1][0],
        curmonIsolationClose:  regs_r[1][1],
        curmonEnable:          regs_r[1][2],
        curmonStrobe:          cm3Strobe,
        curmonTrack:           cm3Track,
        comparatorEnable:      regs_r[1][4],
        tempmonBypassSelect:   regs_r[2][0],
        tempmonIsolationClose: regs_r[2][1],
        tempmonSwitches:
            monitor_cfg_pkg::TM_SWITCH_TABLE[tm3Phase],
        tempmonPhase:          tm3Phase};
    assign unit4Out = '{
        curmonBypassSelect:    regs_r[3][0],
        curmonIsolationClose:  regs_r[3][1],
        curmonEnable:          regs_r[3][2],
        curmonStrobe:          cm4Strobe,
        curmonTrack:           cm4Track,
        comparatorEnable:      regs_r[3][4],
        tempmonBypassSelect:   regs_r[4][0],
        tempmonIsolationClose: regs_r[4][1],
        tempmonSwitches:
            monitor_cfg_pkg::TM_SWITCH_TABLE[tm4Phase],
        tempmonPhase:          tm4Phase};

    // Offset compensation of temperature conversion results
    always_ff @(posedge sys_clk)
    begin
        if (!resetn)
        begin
            comp_r      <= '0;
            compValid_r <= 1'b0;
        end
        else
        begin
            compValid_r <= tmResultValid;
            if (tmResultValid)
                comp_r <= tmResult + tmFactoryOffset;
        end
    end

    assign tmCompResult = comp_r;
    assign tmCompValid  = compValid_r;

    a_upper_zero: assert property (@(posedge sys_clk)
        disable iff (!resetn) sysRdata[31:8] == 24'h000000)
        else $error("upper read bits not zero");

    // Write, one quiet cycle, then read back the same word
    a_write_store: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        sysWrite && sysHit[1] ##1 !sysWrite && !aceWrite
        ##1 sysRead && sysHit[1]
        |=> sysRdata[7:0] ==
            ($past(sysWdata[7:0], 3) & monitor_cfg_pkg::CM_MASK))
        else $error("stored value or mask wrong");

    a_eff_strobe: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        unit3Out.curmonStrobe == (regs_r[1][3] | regs_r[0][3]))
        else $error("effective strobe not local OR global");

    a_cm_idle: assert property (@(posedge sys_clk)
        disable iff (!resetn) !cm3Strobe |=> cm3Phase == 2'h0)
        else $error("current monitor not idle");

    a_tm_idle_sw: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        !tm3Strobe |=> unit3Out.tempmonSwitches == 4'hD)
        else $error("idle switch pattern wrong");

    a_unit4_gone: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        !HAS_UNIT4 |-> regs_r[3] == 8'h00 && regs_r[4] == 8'h00)
        else $error("absent unit holds bits");

    a_comp_result: assert property (@(posedge sys_clk)
        disable iff (!resetn)
        tmResultValid |=> tmCompValid
        && tmCompResult == RESULT_W'($past(tmResult)
                                     + $past(tmFactoryOffset)))
        else $error("compensated result wrong");

    a_reset_clear: assert property (@(posedge sys_clk)
        !resetn |=> regs_r[1] == 8'h00 && regs_r[2] == 8'h00)
        else $error("control bits not cleared by reset");

endmodule

// ---- bench/monitor_partner.sv ----
// Behavioural analog monitor and converter facing unit 3
`timescale 1ns/1ns
module monitor_partner #(
    parameter int          SETTLE = 600,
    parameter logic [11:0] CODE   = 12'hF00
) (
    input  wire logic                          sys_clk,
    input  wire monitor_cfg_pkg::unit_out_type unit3Out,
    output logic [11:0]                        tmResult,
    output logic                               tmResultValid
);
    logic [15:0] settleCnt = 16'h0000;
    logic [11:0] noise     = 12'h000;
    logic        validR    = 1'b0;

    // Converter samples once the amplified last phase has settled
    always_ff @(posedge sys_clk)
    begin
        noise  <= noise + 12'h5A7;
        validR <= 1'b0;
        if (unit3Out.tempmonPhase != 3'h4)
            settleCnt <= 16'h0000;
        else if (settleCnt != 16'hFFFF)
            settleCnt <= settleCnt + 16'h0001;
        if (settleCnt == 16'(SETTLE))
            validR <= 1'b1;
    end

    // Outside a valid cycle the result lines carry a changing pattern
    assign tmResultValid = validR;
    assign tmResult      = validR ? CODE : noise;
endmodule

// ---- bench/tb_top.sv ----
// Self-checking bench for the monitor control bit bank
`timescale 1ns/1ns
module tb_top;
    localparam logic [4:0][7:0] MASKS = {
        monitor_cfg_pkg::TM_MASK, monitor_cfg_pkg::CM_MASK,
        monitor_cfg_pkg::TM_MASK, monitor_cfg_pkg::CM_MASK,
        monitor_cfg_pkg::GSTB_MASK};
    localparam logic [11:0] CODE = 12'hF00;

    logic                          sys_clk         = 1'b0;
    logic                          resetn          = 1'b0;
    logic [31:0]                   sysAddr         = 32'h0;
    logic                          sysWrite        = 1'b0;
    logic                          sysRead         = 1'b0;
    logic [31:0]                   sysWdata        = 32'h0;
    logic [31:0]                   sysRdata;
    logic [7:0]                    aceAddr         = 8'h00;
    logic                          aceWrite        = 1'b0;
    logic                          aceRead         = 1'b0;
    logic [7:0]                    aceWdata        = 8'h00;
    logic [7:0]                    aceRdata;
    logic [11:0]                   tmResult;
    logic                          tmResultValid;
    logic [11:0]                   tmFactoryOffset = 12'h180;
    logic [11:0]                   tmCompResult;
    logic                          tmCompValid;
    monitor_cfg_pkg::unit_out_type unit3Out;
    monitor_cfg_pkg::unit_out_type unit4Out;
    logic [31:0]                   rd;
    int                            errTotal        = 0;
    int                            testsRun        = 0;

    monitor_config_control_bits #(.HAS_UNIT4(1'b1), .RESULT_W(12)) i_dut (
        .sys_clk(sys_clk), .resetn(resetn), .sysAddr(sysAddr),
        .sysWrite(sysWrite), .sysRead(sysRead), .sysWdata(sysWdata),
        .sysRdata(sysRdata), .aceAddr(aceAddr), .aceWrite(aceWrite),
        .aceRead(aceRead), .aceWdata(aceWdata), .aceRdata(aceRdata),
        .tmResult(tmResult), .tmResultValid(tmResultValid),
        .tmFactoryOffset(tmFactoryOffset), .tmCompResult(tmCompResult),
        .tmCompValid(tmCompValid), .unit3Out(unit3Out), .unit4Out(unit4Out));

    monitor_partner #(.SETTLE(600), .CODE(CODE)) i_partner (
        .sys_clk(sys_clk), .unit3Out(unit3Out), .tmResult(tmResult),
        .tmResultValid(tmResultValid));

    // Free-running system clock
    initial
    begin
        forever #5 sys_clk = ~sys_clk;
    end

    // Compare and count
    task automatic chk(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
        testsRun++;
        if (seen !== exp)
        begin
            errTotal++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Verdict and end of run
    task automatic testDone;
        $display("Comparisons %0d mismatches %0d", testsRun, errTotal);
        if (errTotal == 0 && testsRun > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // One access on either port; read data lands after the taking edge
    task automatic acc(input bit ace, input bit wr, input logic [31:0] a,
                       input logic [31:0] d, output logic [31:0] r);
        @(posedge sys_clk);
        if (ace)
        begin
            aceAddr  <= a[7:0];
            aceWdata <= d[7:0];
            aceWrite <= wr;
            aceRead  <= !wr;
        end
        else
        begin
            sysAddr  <= a;
            sysWdata <= d;
            sysWrite <= wr;
            sysRead  <= !wr;
        end
        @(posedge sys_clk);
        aceWrite <= 1'b0;
        aceRead  <= 1'b0;
        sysWrite <= 1'b0;
        sysRead  <= 1'b0;
        #1;
        r = ace ? {24'h0, aceRdata} : sysRdata;
    endtask

    function automatic logic [31:0] addrOf(input bit ace, input int i);
        return ace ? {24'h0, monitor_cfg_pkg::ACE_ADDR[i]}
                   : monitor_cfg_pkg::SYS_ADDR[i];
    endfunction

    task automatic wreg(input bit ace, input int i, input logic [31:0] d);
        logic [31:0] r;
        acc(ace, 1'b1, addrOf(ace, i), d, r);
    endtask

    task automatic rchk(input bit ace, input int i, input logic [31:0] e);
        logic [31:0] r;
        acc(ace, 1'b0, addrOf(ace, i), 32'h0, r);
        chk($sformatf("slot%0d port%0d", i, ace), r, e);
    endtask

    // Bounded wait for the compensated result pulse
    task automatic waitResult;
        int n;
        n = 0;
        while (tmCompValid !== 1'b1)
        begin
            @(posedge sys_clk);
            #1;
            n++;
            if (n > 3000)
            begin
                errTotal++;
                $display("Error result wait expected pulse seen none");
                testDone();
            end
        end
    endtask

    // Main sequence
    initial
    begin
        repeat (20) @(posedge sys_clk);
        resetn <= 1'b1;
        // Reset values through both ports
        for (int p = 0; p < 2; p++)
            for (int i = 0; i < 5; i++)
                rchk(p, i, 32'h0);
        // All ones written, only implemented low bits return
        for (int p = 0; p < 2; p++)
            for (int i = 0; i < 5; i++)
            begin
                wreg(p, i, 32'hFFFFFFFF);
                rchk(p, i, {24'h0, MASKS[i]});
            end
        chk("u3 static", {unit3Out.curmonBypassSelect,
            unit3Out.curmonIsolationClose, unit3Out.curmonEnable,
            unit3Out.comparatorEnable, unit3Out.tempmonBypassSelect,
            unit3Out.tempmonIsolationClose}, 6'h3F);
        chk("u4 static", {unit4Out.curmonBypassSelect,
            unit4Out.curmonIsolationClose, unit4Out.curmonEnable,
            unit4Out.comparatorEnable, unit4Out.tempmonBypassSelect,
            unit4Out.tempmonIsolationClose}, 6'h3F);
        // Neighbouring unmapped words ignore writes and read zero
        acc(1'b0, 1'b1, 32'h400202C0, 32'hFF, rd);
        acc(1'b0, 1'b0, 32'h400202C0, 32'h0, rd);
        chk("unmapped sys", rd, 32'h0);
        acc(1'b1, 1'b1, 32'h000000B0, 32'hFF, rd);
        acc(1'b1, 1'b0, 32'h000000B0, 32'h0, rd);
        chk("unmapped ace", rd, 32'h0);
        for (int i = 0; i < 5; i++)
            wreg(1'b0, i, 32'h0);
        // Each current field drives only its own output, both units
        for (int b = 0; b < 5; b++)
        begin
            wreg(1'b0, 1, 32'h1 << b);
            wreg(1'b1, 3, 32'h1 << b);
            chk("u3 cm field", {unit3Out.comparatorEnable,
                unit3Out.curmonStrobe, unit3Out.curmonEnable,
                unit3Out.curmonIsolationClose,
                unit3Out.curmonBypassSelect},
                5'h1 << b);
            chk("u4 cm field", {unit4Out.comparatorEnable,
                unit4Out.curmonStrobe, unit4Out.curmonEnable,
                unit4Out.curmonIsolationClose,
                unit4Out.curmonBypassSelect},
                5'h1 << b);
        end
        wreg(1'b0, 1, 32'h0);
        wreg(1'b0, 3, 32'h0);
        // Temperature bypass and isolation fields
        for (int b = 0; b < 2; b++)
        begin
            wreg(1'b0, 2, 32'h1 << b);
            chk("u3 tm field", {unit3Out.tempmonIsolationClose,
                unit3Out.tempmonBypassSelect}, 2'h1 << b);
        end
        // Effective strobe is local OR global
        for (int c = 0; c < 4; c++)
        begin
            wreg(1'b0, 1, c[0] ? 32'h08 : 32'h0);
            wreg(1'b1, 0, c[1] ? 32'h08 : 32'h0);
            chk("u3 strobe", unit3Out.curmonStrobe, c != 0);
            chk("u4 strobe", unit4Out.curmonStrobe, 1'b0);
        end
        for (int i = 0; i < 5; i++)
            wreg(1'b0, i, 32'h0);
        repeat (3) @(posedge sys_clk);
        // Usual setup: amplifier path, switches open, comparator off
        wreg(1'b0, 1, 32'h04);
        wreg(1'b0, 1, 32'h0C);
        repeat (50) @(posedge sys_clk);
        chk("cm idle", unit3Out.curmonTrack, 1'b0);
        repeat (260) @(posedge sys_clk);
        chk("cm track", unit3Out.curmonTrack, 1'b1);
        wreg(1'b0, 1, 32'h04);
        repeat (3) @(posedge sys_clk);
        chk("cm drop", unit3Out.curmonTrack, 1'b0);
        // Global strobes start both monitors together
        wreg(1'b0, 0, 32'h18);
        repeat (310) @(posedge sys_clk);
        chk("gl track", {unit3Out.curmonTrack, unit4Out.curmonTrack},
            2'h3);
        wreg(1'b0, 0, 32'h0);
        wreg(1'b0, 1, 32'h0);
        repeat (3) @(posedge sys_clk);
        // Temperature sequence through all phases on two units
        wreg(1'b0, 2, 32'h04);
        wreg(1'b0, 4, 32'h04);
        repeat (48) @(posedge sys_clk);
        for (int k = 0; k < 5; k++)
        begin
            chk("tm phase", unit3Out.tempmonPhase, k);
            chk("tm sw", unit3Out.tempmonSwitches,
                monitor_cfg_pkg::TM_SWITCH_TABLE[k]);
            chk("u4 phase", unit4Out.tempmonPhase, k);
            repeat (100) @(posedge sys_clk);
        end
        // Strobe held until the converted sample is in
        waitResult();
        chk("tm hold", unit3Out.tempmonPhase, 3'h4);
        chk("tm comp", tmCompResult, 12'(CODE + 12'h180));
        @(posedge sys_clk);
        #1;
        chk("comp pulse", tmCompValid, 1'b0);
        wreg(1'b0, 2, 32'h0);
        wreg(1'b0, 4, 32'h0);
        repeat (3) @(posedge sys_clk);
        chk("tm idle", unit3Out.tempmonPhase, 3'h0);
        chk("tm idle sw", unit3Out.tempmonSwitches,
            monitor_cfg_pkg::TM_SWITCH_TABLE[0]);
        // Mid-run reset clears stored bits
        wreg(1'b0, 1, 32'h1F);
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        chk("rst enable", unit3Out.curmonEnable, 1'b0);
        rchk(1'b0, 1, 32'h0);
        testDone();
    end
endmodule
